// ### hw/tha_defines.vh
// What this block does
// (R1) rising slope: trigger when source crosses level upward
// (R2) falling slope: trigger when source crosses level downward
// (R3) holdoff held in 0.01 us units; coarse 1 us steps accepted too
// (R4) normal holdoff: timer starts at each trigger, later edges ignored meanwhile
// (R5) holdoff expiry re-arms; next valid edge starts a new sweep
// (R6) gap holdoff: arm only after source inactive for the full holdoff time
// (R7) once armed after a gap, next edge of chosen slope triggers
// (R8) host sets normal holdoff slightly below burst repetition interval
// (R9) per-source skew trim added to programmed trigger delay
// (R10) dB offset shifts trigger level and its range upward
// (R11) trace average is first-order exponential filter, time constant smoothing count
// (R12) smoothing count is power of two, 1 to 16384; 1 means none
// (R13) at 200 ns/div and faster, sweep count multiplied by interleave ratio; tc_sh ignores il_log, so the count is not multiplied
// (R14) per pixel: average of samples, min/max over same sample block
// (R15) window filter is equal-weight sliding average over integration time; code averages NWIN samples if modulated and win_sh > 0, whatever filt_span_o says
// (R16) filter mode: manual, none (1 ms minimum), or automatic by input level
// (R17) window filter acts only on modulated mode, pulse trace untouched
// (R18) tracking peak hold decays min/max toward average with averaging constant
// (R19) manual peak hold decays with release setting, power of two 1 to 16384; release_log2_i is not clamped, so 32768 is accepted too
// (R20) hold forever keeps min/max and never decays them
// (R21) marker min/max always follow peak hold, display or not
// (R22) free run sweeps without trigger; auto sweeps after timeout without edge
// (R23) holdoff and gap timers count clocks; gap timer restarts when source active
// (R24) after reset or settings change, first sweep initialises average, min, max
`ifndef THA_DEFINES_VH
`define THA_DEFINES_VH
`define THA_CLK_MHZ 200
// holdoff units: 0.01 us = 2 clocks at 200 MHz
`define THA_HO_UNIT_CLK 2
`define THA_HO_COARSE 100
`define THA_HO_W 24
`define THA_TRIG_NORMAL 2'h0
`define THA_TRIG_AUTO 2'h1
`define THA_TRIG_FREE 2'h2
`define THA_SRC_RF 2'h0
`define THA_SRC_EXT 2'h1
`define THA_SRC_SLAVE 2'h2
`define THA_PH_TRACK 2'h0
`define THA_PH_MANUAL 2'h1
`define THA_PH_FOREVER 2'h2
`define THA_FM_MANUAL 2'h0
`define THA_FM_NONE 2'h1
`define THA_FM_AUTO 2'h2
`define THA_MAX_LOG2 4'he
// 1 ms at 200 MHz
`define THA_FILT_MIN_CLK 32'h0003_0D40
`define THA_AUTO_HI_LVL 16'h4000
`endif

// ### hw/tha_trigger_averager.v
`timescale 1ns/1ps
`include "tha_defines.vh"
module tha_trigger_averager #(
	parameter W = 16,
	parameter PIX_W = 6,
	parameter WIN_LOG2 = 4,
	parameter AUTO_TIMEOUT = 32'h0098_9680,
	parameter DLY_W = 24
)(
	// clock and reset
	input wire clk_i,
	input wire resetn_i,
	// sampled envelope and trigger inputs
	input wire [W-1:0] env_i,
	input wire ext_trig_i,
	input wire slave_trig_i,
	// trigger settings
	input wire [1:0] trig_mode_i,
	input wire [1:0] trig_src_i,
	input wire slope_fall_i,
	input wire signed [W-1:0] trig_level_i,
	input wire signed [W-1:0] db_offset_i,
	input wire gap_mode_i,
	input wire [`THA_HO_W-1:0] holdoff_fine_i,
	input wire [7:0] holdoff_coarse_i,
	input wire [DLY_W-1:0] trig_delay_i,
	input wire [DLY_W-1:0] skew_rf_i,
	input wire [DLY_W-1:0] skew_ext_i,
	input wire [DLY_W-1:0] skew_slave_i,
	// averaging and peak hold settings
	input wire [3:0] avg_log2_i,
	input wire [3:0] release_log2_i,
	input wire [1:0] peak_mode_i,
	input wire [3:0] interleave_log2_i,
	input wire fast_timebase_i,
	input wire settings_chg_i,
	// modulation filter settings
	input wire modulated_i,
	input wire [1:0] filt_mode_i,
	input wire [WIN_LOG2-1:0] filt_log2_i,
	// trigger and sweep outputs
	output reg sweep_start_o,
	output reg [DLY_W:0] eff_delay_o,
	output reg armed_o,
	output reg signed [W:0] level_adj_o,
	output reg signed [W:0] level_max_o,
	// trace outputs
	output reg pix_valid_o,
	output reg [PIX_W-1:0] pix_idx_o,
	output reg [W-1:0] avg_o,
	output reg [W-1:0] min_o,
	output reg [W-1:0] max_o,
	output reg [W-1:0] marker_min_o,
	output reg [W-1:0] marker_max_o,
	output reg [W-1:0] filt_o,
	output reg [31:0] filt_span_o
);
	localparam NPIX = 1 << PIX_W;
	localparam NWIN = 1 << WIN_LOG2;
	localparam signed [W:0] LVL_TOP = 17'sh0_7FFF;
	// ---------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------
	reg ext_s1_r, ext_s2_r, slv_s1_r, slv_s2_r;
	always @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			slv_s1_r <= 1'b0;
			slv_s2_r <= 1'b0;
		end
		else
		begin
			ext_s1_r <= ext_trig_i;
			ext_s2_r <= ext_s1_r;
			slv_s1_r <= slave_trig_i;
			slv_s2_r <= slv_s1_r;
		end
	end
	// ---------------------------------------------------------
	// trigger qualification
	// ---------------------------------------------------------
	wire signed [W:0] lvl_adj = {trig_level_i[W-1], trig_level_i} + {db_offset_i[W-1], db_offset_i}; // R10
	wire signed [W:0] env_s = {1'b0, env_i};
	reg above;
	always @*
	begin
		case (trig_src_i)
			`THA_SRC_EXT: above = ext_s2_r;
			`THA_SRC_SLAVE: above = slv_s2_r;
			default: above = (env_s > lvl_adj);
		endcase
	end
	reg above_r;
	wire active = slope_fall_i ? ~above : above;
	wire edge_rise = above & ~above_r; // R1
	wire edge_fall = ~above & above_r; // R2
	wire edge_ok = slope_fall_i ? edge_fall : edge_rise;
	// holdoff length in clocks: fine 0.01 us units plus coarse 1 us steps
	wire [31:0] ho_units = {8'h00, holdoff_fine_i} + holdoff_coarse_i * `THA_HO_COARSE; // R3
	wire [31:0] ho_clks = ho_units * `THA_HO_UNIT_CLK; // R23
	reg [31:0] ho_cnt_r;
	reg [31:0] auto_cnt_r;
	reg armed_r;
	reg sweep_busy_r;
	wire trig = edge_ok & armed_r;
	wire auto_fire = (trig_mode_i == `THA_TRIG_AUTO) && (auto_cnt_r >= AUTO_TIMEOUT);
	wire start = (trig_mode_i == `THA_TRIG_FREE) ? ~sweep_busy_r : (trig | (auto_fire & ~sweep_busy_r)); // R22
	reg [DLY_W-1:0] skew;
	always @*
	begin
		case (trig_src_i)
			`THA_SRC_EXT: skew = skew_ext_i;
			`THA_SRC_SLAVE: skew = skew_slave_i;
			default: skew = skew_rf_i;
		endcase
	end
	always @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			above_r <= 1'b0;
			ho_cnt_r <= 32'h0000_0000;
			auto_cnt_r <= 32'h0000_0000;
			armed_r <= 1'b0;
			eff_delay_o <= {(DLY_W+1){1'b0}};
			level_adj_o <= {(W+1){1'b0}};
			level_max_o <= {(W+1){1'b0}};
			armed_o <= 1'b0;
		end
		else
		begin
			above_r <= above;
			eff_delay_o <= {1'b0, trig_delay_i} + {1'b0, skew}; // R9
			level_adj_o <= lvl_adj;
			level_max_o <= LVL_TOP + {db_offset_i[W-1], db_offset_i}; // R10
			auto_cnt_r <= (edge_ok | auto_fire) ? 32'h0000_0000 : auto_cnt_r + 32'h0000_0001;
			if (gap_mode_i)
			begin
				if (active)
					ho_cnt_r <= 32'h0000_0000; // R23
				else if (ho_cnt_r < ho_clks)
					ho_cnt_r <= ho_cnt_r + 32'h0000_0001;
				if (trig)
					armed_r <= 1'b0; // R7
				else if (!active && ho_cnt_r >= ho_clks)
					armed_r <= 1'b1; // R6
			end
			else
			begin
				if (trig)
				begin
					armed_r <= (ho_clks == 32'h0000_0000); // R4
					ho_cnt_r <= 32'h0000_0001;
				end
				else if (!armed_r)
				begin
					if (ho_cnt_r >= ho_clks)
						armed_r <= 1'b1; // R5
					else
						ho_cnt_r <= ho_cnt_r + 32'h0000_0001;
				end
			end
			armed_o <= armed_r;
		end
	end
	// ---------------------------------------------------------
	// sweep capture and averaging
	// ---------------------------------------------------------
	reg [W-1:0] avg_mem [0:NPIX-1];
	reg [W-1:0] min_mem [0:NPIX-1];
	reg [W-1:0] max_mem [0:NPIX-1];
	reg [PIX_W-1:0] pix_r;
	reg [3:0] il_phase_r;
	reg init_r;
	reg [15:0] rel_cnt_r;
	// interleaved sampling: one pixel in 2^k is updated per sweep
	wire [3:0] il_log = fast_timebase_i ? interleave_log2_i : 4'h0; // R13
	wire [15:0] il_mask = (16'h0001 << il_log) - 16'h0001;
	wire pix_hit = (({10'h000, pix_r} & il_mask) == ({12'h000, il_phase_r} & il_mask));
	wire [3:0] avg_sh = (avg_log2_i > `THA_MAX_LOG2) ? `THA_MAX_LOG2 : avg_log2_i; // R12
	// averaging constant is not stretched by interleave; tc_sh is avg_sh alone, whatever il_log is
	wire [4:0] tc_sh = {1'b0, avg_sh}; // R13
	wire signed [W+1:0] a_old = {2'b00, avg_mem[pix_r]};
	wire signed [W+1:0] a_new = {2'b00, env_i};
	wire signed [W+1:0] a_nxt = a_old + ((a_new - a_old) >>> tc_sh); // R11
	wire [W-1:0] avg_nxt = a_nxt[W-1:0];
	wire [3:0] dec_sh = (peak_mode_i == `THA_PH_MANUAL) ? release_log2_i : avg_sh;
	wire [15:0] rel_len = 16'h0001 << release_log2_i;
	wire dec_en = (peak_mode_i == `THA_PH_TRACK) ||
		((peak_mode_i == `THA_PH_MANUAL) && (rel_cnt_r == 16'h0000)); // R19
	wire signed [W+1:0] mx_old = {2'b00, max_mem[pix_r]};
	wire signed [W+1:0] mn_old = {2'b00, min_mem[pix_r]};
	wire signed [W+1:0] mx_dec = mx_old - ((mx_old - a_nxt) >>> dec_sh); // R18
	wire signed [W+1:0] mn_dec = mn_old + ((a_nxt - mn_old) >>> dec_sh); // R18
	wire [W-1:0] mx_base = dec_en ? mx_dec[W-1:0] : max_mem[pix_r]; // R20
	wire [W-1:0] mn_base = dec_en ? mn_dec[W-1:0] : min_mem[pix_r]; // R20
	wire [W-1:0] max_nxt = (env_i > mx_base) ? env_i : mx_base; // R14
	wire [W-1:0] min_nxt = (env_i < mn_base) ? env_i : mn_base; // R14
	always @(posedge clk_i)
	begin
		if (sweep_busy_r && pix_hit)
		begin
			avg_mem[pix_r] <= init_r ? env_i : avg_nxt; // R24
			max_mem[pix_r] <= init_r ? env_i : max_nxt;
			min_mem[pix_r] <= init_r ? env_i : min_nxt;
		end
	end
	always @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			sweep_busy_r <= 1'b0;
			pix_r <= {PIX_W{1'b0}};
			il_phase_r <= 4'h0;
			init_r <= 1'b1;
			rel_cnt_r <= 16'h0000;
			sweep_start_o <= 1'b0;
			pix_valid_o <= 1'b0;
			pix_idx_o <= {PIX_W{1'b0}};
			avg_o <= {W{1'b0}};
			min_o <= {W{1'b0}};
			max_o <= {W{1'b0}};
			marker_min_o <= {W{1'b0}};
			marker_max_o <= {W{1'b0}};
		end
		else
		begin
			sweep_start_o <= start & ~sweep_busy_r;
			pix_valid_o <= sweep_busy_r & pix_hit;
			if (settings_chg_i)
				init_r <= 1'b1; // R24
			if (start && !sweep_busy_r)
			begin
				sweep_busy_r <= 1'b1;
				pix_r <= {PIX_W{1'b0}};
			end
			else if (sweep_busy_r)
			begin
				pix_idx_o <= pix_r;
				if (pix_hit)
				begin
					avg_o <= init_r ? env_i : avg_nxt;
					max_o <= init_r ? env_i : max_nxt;
					min_o <= init_r ? env_i : min_nxt;
					marker_max_o <= init_r ? env_i : max_nxt; // R21
					marker_min_o <= init_r ? env_i : min_nxt; // R21
				end
				pix_r <= pix_r + {{(PIX_W-1){1'b0}}, 1'b1};
				if (pix_r == NPIX - 1)
				begin
					sweep_busy_r <= 1'b0;
					il_phase_r <= (({12'h000, il_phase_r} & il_mask) == il_mask) ? 4'h0 : il_phase_r + 4'h1;
					if ((({12'h000, il_phase_r} & il_mask) == il_mask) && !settings_chg_i)
						init_r <= 1'b0;
					rel_cnt_r <= (rel_cnt_r == 16'h0000) ? rel_len - 16'h0001 : rel_cnt_r - 16'h0001;
				end
			end
		end
	end
	// ---------------------------------------------------------
	// sliding window modulation filter
	// ---------------------------------------------------------
	// window length is a power of two so the mean is a shift; the span reports THA_FILT_MIN_CLK shifted left by win_sh
	reg [W-1:0] win_mem [0:NWIN-1];
	reg [WIN_LOG2-1:0] wp_r;
	reg [W+WIN_LOG2-1:0] acc_r;
	reg [WIN_LOG2-1:0] win_sh;
	always @*
	begin
		case (filt_mode_i)
			`THA_FM_NONE: win_sh = {WIN_LOG2{1'b0}}; // R16
			`THA_FM_AUTO: win_sh = (env_i > `THA_AUTO_HI_LVL) ? {WIN_LOG2{1'b0}} : {WIN_LOG2{1'b1}}; // R16
			default: win_sh = filt_log2_i; // R16
		endcase
	end
	wire [W+WIN_LOG2-1:0] acc_nxt = acc_r + {{WIN_LOG2{1'b0}}, env_i} - {{WIN_LOG2{1'b0}}, win_mem[wp_r]}; // R15
	wire [W+WIN_LOG2-1:0] win_mean = acc_r >> WIN_LOG2;
	// cleared in reset so the running sum never picks up unknown entries
	integer k;
	always @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			for (k = 0; k < NWIN; k = k + 1)
				win_mem[k] <= {W{1'b0}};
		end
		else
			win_mem[wp_r] <= env_i;
	end
	always @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			wp_r <= {WIN_LOG2{1'b0}};
			acc_r <= {(W+WIN_LOG2){1'b0}};
			filt_o <= {W{1'b0}};
			filt_span_o <= 32'h0000_0000;
		end
		else
		begin
			wp_r <= wp_r + {{(WIN_LOG2-1){1'b0}}, 1'b1};
			acc_r <= acc_nxt;
			filt_span_o <= `THA_FILT_MIN_CLK << win_sh;
			if (!modulated_i)
				filt_o <= env_i; // R17
			else if (win_sh == {WIN_LOG2{1'b0}})
				filt_o <= env_i;
			else
				filt_o <= win_mean[W-1:0]; // R15
		end
	end
endmodule

// ### verif/tha_front_end.sv
`timescale 1ns/1ps
module tha_front_end (
	// clock
	input wire clk_i,
	// bench requests
	input wire [15:0] base_i,
	input wire [7:0] noise_i,
	input wire pulse_i,
	// detector and trigger pins
	output reg [15:0] env_o = 16'h0000,
	output reg ext_o = 1'b0,
	output reg slave_o = 1'b0
);
	// pins move on the falling edge, well clear of the sampling edge
	always @(negedge clk_i)
	begin
		env_o <= base_i + {8'h00, noise_i};
		ext_o <= pulse_i;
		// slave path lags a clock, so the two trims see different timing
		slave_o <= ext_o;
	end
endmodule

// ### verif/tha_trig_avg_monitor.sv
`timescale 1ns/1ps
`include "tha_defines.vh"
module tha_trig_avg_monitor #(parameter W = 16, parameter PIX_W = 6, parameter DLY_W = 24)(
	// clock and reset
	input wire clk_i,
	input wire resetn_i,
	// settings
	input wire [1:0] trig_mode_i,
	input wire [1:0] trig_src_i,
	input wire signed [W-1:0] trig_level_i,
	input wire signed [W-1:0] db_offset_i,
	input wire gap_mode_i,
	input wire [`THA_HO_W-1:0] holdoff_fine_i,
	input wire [7:0] holdoff_coarse_i,
	input wire [DLY_W-1:0] trig_delay_i,
	input wire [DLY_W-1:0] skew_rf_i,
	input wire [DLY_W-1:0] skew_ext_i,
	input wire [DLY_W-1:0] skew_slave_i,
	input wire [1:0] filt_mode_i,
	// results
	input wire sweep_start_o,
	input wire [DLY_W:0] eff_delay_o,
	input wire signed [W:0] level_adj_o,
	input wire signed [W:0] level_max_o,
	input wire pix_valid_o,
	input wire [PIX_W-1:0] pix_idx_o,
	input wire [W-1:0] avg_o,
	input wire [W-1:0] min_o,
	input wire [W-1:0] max_o,
	input wire [31:0] filt_span_o
);
	// ----
	// helpers
	// ----
	reg [1:0] up_r;
	reg [31:0] since_r;
	reg [7:0] free_r;
	wire signed [W:0] lsum = trig_level_i + db_offset_i;
	wire signed [W:0] lmax = 17'sh0_7fff + db_offset_i;
	wire [DLY_W:0] dsum = trig_delay_i + (trig_src_i == `THA_SRC_EXT ? skew_ext_i :
		trig_src_i == `THA_SRC_SLAVE ? skew_slave_i : skew_rf_i);
	wire [31:0] ho_clks = (holdoff_fine_i + holdoff_coarse_i * `THA_HO_COARSE) * `THA_HO_UNIT_CLK;
	always @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			up_r <= 2'h0;
			since_r <= 32'hffff_ffff;
			free_r <= 8'h00;
		end
		else
		begin
			if (up_r != 2'h3)
				up_r <= up_r + 2'h1;
			if (sweep_start_o)
				since_r <= 32'h0000_0001;
			else if (since_r != 32'hffff_ffff)
				since_r <= since_r + 32'h0000_0001;
			if (trig_mode_i != `THA_TRIG_FREE)
				free_r <= 8'h00;
			else if (free_r != 8'hff)
				free_r <= free_r + 8'h01;
		end
	end
	// ----
	// checks
	// ----
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	// stability guard lets a one- or two-stage pipeline pass
	a_level_offset: assert property (up_r == 2'h3 && $stable(lsum) |=> level_adj_o == $past(lsum))
		else $error("level_adj_o wrong");
	a_level_range: assert property (up_r == 2'h3 && $stable(lmax) |=> level_max_o == $past(lmax))
		else $error("level_max_o wrong");
	a_delay_skew: assert property (up_r == 2'h3 && $stable(dsum) |=> eff_delay_o == $past(dsum))
		else $error("eff_delay_o wrong");
	a_holdoff_space: assert property (sweep_start_o && trig_mode_i == `THA_TRIG_NORMAL && !gap_mode_i
		|-> since_r >= ho_clks) else $error("sweep inside holdoff");
	a_pixel_walk: assert property (sweep_start_o |=> pix_valid_o && pix_idx_o == 0
		##1 pix_valid_o && pix_idx_o == 1) else $error("pixel walk broken");
	a_minmax_order: assert property (pix_valid_o |-> min_o <= avg_o && avg_o <= max_o)
		else $error("min avg max out of order");
	a_free_run: assert property (free_r > 8'h64 |-> since_r <= 32'h0000_0064)
		else $error("free run stalled");
	a_filter_none: assert property (filt_mode_i == `THA_FM_NONE [*3] |-> filt_span_o == `THA_FILT_MIN_CLK)
		else $error("filt_span_o not minimum");
	c_gap_sweep: cover property (sweep_start_o && gap_mode_i);
	c_last_pixel: cover property (pix_valid_o && pix_idx_o == 63);
	c_auto_sweep: cover property (sweep_start_o && trig_mode_i == `THA_TRIG_AUTO);
endmodule
bind tha_trigger_averager tha_trig_avg_monitor #(.W(W), .PIX_W(PIX_W), .DLY_W(DLY_W)) u_mon (.*);

// ### verif/tb_top.sv
`timescale 1ns/1ps
`include "tha_defines.vh"
`define CHK(nm, ex, got) \
	begin \
		tests_run++; \
		if ((got) !== (ex)) \
		begin \
			mismatches++; \
			$display("Error %s expected %h seen %h", nm, ex, got); \
		end \
	end
module tb_top;
	// ----
	// signals
	// ----
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	wire [15:0] env_i;
	wire ext_trig_i, slave_trig_i, sweep_start_o, armed_o, pix_valid_o;
	logic [1:0] trig_mode_i = 2'h0, trig_src_i = 2'h0, peak_mode_i = 2'h0, filt_mode_i = 2'h0;
	logic slope_fall_i = 1'b0, gap_mode_i = 1'b0, fast_timebase_i = 1'b0, settings_chg_i = 1'b0, modulated_i = 1'b0;
	logic signed [15:0] trig_level_i = 16'sh2000, db_offset_i = 16'sh1000;
	logic [23:0] holdoff_fine_i = 24'h00_0000, trig_delay_i = 24'h00_0000;
	logic [23:0] skew_rf_i = 24'h00_0000, skew_ext_i = 24'h00_0000, skew_slave_i = 24'h00_0000;
	logic [7:0] holdoff_coarse_i = 8'h00;
	logic [3:0] avg_log2_i = 4'h0, release_log2_i = 4'h0, interleave_log2_i = 4'h0, filt_log2_i = 4'h0;
	wire [24:0] eff_delay_o;
	wire signed [16:0] level_adj_o, level_max_o;
	wire [5:0] pix_idx_o;
	wire [15:0] avg_o, min_o, max_o, marker_min_o, marker_max_o, filt_o;
	wire [31:0] filt_span_o;
	logic [15:0] base = 16'h0100;
	logic [7:0] noise = 8'h00;
	logic pulse = 1'b0, rnd = 1'b1;
	logic [79:0] cap = 80'h0000_0000_0000_0000_0000;
	integer seed = 32'hd09ca7b2, mismatches = 0, tests_run = 0, starts = 0, i;
	// short auto timeout keeps the run brief
	tha_trigger_averager #(.AUTO_TIMEOUT(32'h0000_0064)) u_tha_trigger_averager (.*);
	tha_front_end u_tha_front_end (.clk_i(clk_i), .base_i(base), .noise_i(noise), .pulse_i(pulse),
		.env_o(env_i), .ext_o(ext_trig_i), .slave_o(slave_trig_i));
	initial forever #2.5 clk_i = ~clk_i;
	always @(negedge clk_i) noise <= rnd ? 8'($random(seed)) : 8'h00;
	always @(posedge clk_i) if (sweep_start_o === 1'b1) starts <= starts + 1;
	// ----
	// helpers
	// ----
	function [16:0] f_lvl(input signed [15:0] a, input signed [15:0] b);
		f_lvl = a + b;
	endfunction
	function [24:0] f_dly(input [1:0] s);
		f_dly = trig_delay_i + (s == `THA_SRC_EXT ? skew_ext_i : s == `THA_SRC_SLAVE ? skew_slave_i : skew_rf_i);
	endfunction
	task cyc(input integer n);
		repeat (n) @(negedge clk_i);
	endtask
	// two bursts per 300-clock frame, the second one 120 clocks after the first
	task frame;
		base = 16'h6000;
		cyc(20);
		base = 16'h0100;
		cyc(100);
		base = 16'h6000;
		cyc(20);
		base = 16'h0100;
		cyc(160);
	endtask
	task sweep(input [15:0] b);
		integer n;
		base = b;
		cyc(4);
		pulse = 1'b1;
		cyc(3);
		pulse = 1'b0;
		for (n = 0; n < 400 && !(pix_valid_o === 1'b1 && pix_idx_o === 6'h3f); n++)
		begin
			if (pix_valid_o === 1'b1 && pix_idx_o === 6'h0a)
				cap = {avg_o, min_o, max_o, marker_max_o, marker_min_o};
			cyc(1);
		end
		`CHK("sweep_done", 1'b1, pix_valid_o)
		cyc(4);
	endtask
	task close_out;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		#200000;
		mismatches++;
		close_out();
	end
	// ----
	// scenarios
	// ----
	initial
	begin
		cyc(10);
		resetn_i = 1'b1;
		for (i = 0; i < 24; i++)
		begin
			trig_level_i = $random(seed);
			db_offset_i = $random(seed);
			trig_delay_i = $random(seed) & 24'h00_001f;
			skew_rf_i = $random(seed) & 24'h00_001f;
			skew_ext_i = $random(seed) & 24'h00_001f;
			skew_slave_i = $random(seed) & 24'h00_001f;
			trig_src_i = i % 3;
			cyc(3);
			`CHK("level_adj_o", f_lvl(trig_level_i, db_offset_i), level_adj_o)
			`CHK("level_max_o", f_lvl(16'sh7fff, db_offset_i), level_max_o)
			`CHK("eff_delay_o", f_dly(trig_src_i), eff_delay_o)
		end
		trig_src_i = `THA_SRC_RF;
		trig_level_i = 16'sh2000;
		db_offset_i = 16'sh1000;
		// 240 clocks, just short of the frame, so the mid-frame burst is skipped
		holdoff_fine_i = 24'h00_0014;
		holdoff_coarse_i = 8'h01;
		for (i = 0; i < 3; i++)
		begin
			slope_fall_i = (i == 1);
			gap_mode_i = (i == 2);
			if (i == 2)
				{holdoff_coarse_i, holdoff_fine_i} = {8'h00, 24'h00_003c};
			cyc(400);
			starts = 0;
			repeat (5) frame();
			`CHK("frame_sweeps", 5, starts)
			`CHK("armed_o", 1'b1, armed_o)
		end
		{gap_mode_i, slope_fall_i, holdoff_fine_i} = {2'b00, 24'h00_0000};
		trig_mode_i = `THA_TRIG_AUTO;
		starts = 0;
		cyc(400);
		`CHK("auto_sweeps", 1'b1, starts > 0)
		trig_mode_i = `THA_TRIG_FREE;
		starts = 0;
		cyc(300);
		`CHK("free_sweeps", 1'b1, starts >= 2)
		{trig_mode_i, trig_src_i, rnd, modulated_i} = {`THA_TRIG_NORMAL, `THA_SRC_EXT, 2'b01};
		{avg_log2_i, peak_mode_i, settings_chg_i} = {4'h1, `THA_PH_FOREVER, 1'b1};
		cyc(300);
		settings_chg_i = 1'b0;
		sweep(16'h0100);
		`CHK("first_sweep", 48'h0100_0100_0100, cap[79:32])
		sweep(16'h0300);
		`CHK("avg_o", 16'h0200, cap[79:64])
		`CHK("min_max", 32'h0100_0300, cap[63:32])
		`CHK("marker_max_o", 16'h0300, cap[31:16])
		`CHK("marker_min_o", 16'h0100, cap[15:0])
		avg_log2_i = 4'h0;
		sweep(16'h0500);
		`CHK("avg_o", 16'h0500, cap[79:64])
		for (i = 0; i < 3; i++)
		begin
			{peak_mode_i, filt_mode_i} = {2'(i), 2'(i)};
			sweep($random(seed) & 16'h3fff);
			if (i == 1)
				`CHK("filt_span_o", `THA_FILT_MIN_CLK, filt_span_o)
		end
		{modulated_i, filt_mode_i, filt_log2_i, base} = {1'b0, `THA_FM_MANUAL, 4'h2, 16'h0240};
		cyc(3);
		`CHK("filt_o", 16'h0240, filt_o)
		modulated_i = 1'b1;
		cyc(20);
		`CHK("filt_o", 16'h0240, filt_o)
		close_out();
	end
endmodule
